// File: verilog/speed_encoder_pkg.sv
package speed_encoder_pkg;

  // Differential field samples arrive as signed gauss codes, one LSB per gauss
  localparam int SAMPLE_W = 12;
  typedef logic signed [SAMPLE_W-1:0] field_t;

  typedef struct packed {
    field_t chan_a;
    field_t chan_b;
  } field_pair_t;

  typedef enum logic [1:0] {
    KIND_FWD,
    KIND_REV,
    KIND_WARN
  } pulse_kind_t;

  // Clock and pulse timing
  localparam int CLOCK_NS      = 100;
  localparam int PRE_WIDTH_US  = 50;
  localparam int FWD_WIDTH_US  = 60;
  localparam int REV_WIDTH_US  = 120;
  localparam int WARN_WIDTH_US = 30;
  localparam int ERR_PHASE_US  = 240;

  localparam int CNT_W = 12;
  // Widths round up to whole clock cycles so no phase comes out short
  localparam logic [CNT_W-1:0] PRE_CYCLES  =
    CNT_W'((PRE_WIDTH_US * 1000 + CLOCK_NS - 1) / CLOCK_NS);
  localparam logic [CNT_W-1:0] FWD_CYCLES  =
    CNT_W'((FWD_WIDTH_US * 1000 + CLOCK_NS - 1) / CLOCK_NS);
  localparam logic [CNT_W-1:0] REV_CYCLES  =
    CNT_W'((REV_WIDTH_US * 1000 + CLOCK_NS - 1) / CLOCK_NS);
  localparam logic [CNT_W-1:0] WARN_CYCLES =
    CNT_W'((WARN_WIDTH_US * 1000 + CLOCK_NS - 1) / CLOCK_NS);
  localparam logic [CNT_W-1:0] ERR_CYCLES  =
    CNT_W'((ERR_PHASE_US * 1000 + CLOCK_NS - 1) / CLOCK_NS);
  localparam logic [CNT_W-1:0] CNT_ZERO    = CNT_W'(0);
  localparam logic [CNT_W-1:0] CNT_ONE     = CNT_W'(1);

  // Dynamic thresholds in percent of processed peak-to-peak
  localparam int OP_PERCENT   = 60;
  localparam int RP_PERCENT   = 40;
  localparam int FULL_PERCENT = 100;

  // Amplitude limits in gauss
  localparam int MIN_PKPK_G  = 20;
  localparam int WARN_PKPK_G = 24;

  // One and a half input cycles are three switching-channel crossings
  localparam logic [1:0] CAL_CROSSINGS = 2'h3;

endpackage

// File: verilog/speed_direction_pulse_encoder.sv
`timescale 1ns/1ps
module speed_direction_pulse_encoder #(
  parameter bit REVERSED_VARIANT = 1'b0,
  parameter bit WARNING_VARIANT  = 1'b0
) (
  input  wire logic                        clock_i,
  input  wire logic                        rst_i,
  input  wire logic                        sample_valid_i,
  input  wire speed_encoder_pkg::field_pair_t field_i,
  input  wire logic                        fault_i,
  output logic                             current_high_o,
  output logic                             calibrated_o,
  output logic                             switch_chan_o,
  output logic                             safe_state_o
);

  typedef enum {ST_REST, ST_PRE, ST_HIGH, ST_SAFE} out_state_t;

  speed_encoder_pkg::field_t smp [2];
  logic                      chan_state [2];
  logic                      next_chan_state [2];
  logic                      chan_edge [2];
  int                        chan_pkpk [2];

  assign smp[0] = field_i.chan_a;
  assign smp[1] = field_i.chan_b;

  // Per-channel peak tracking and hysteresis comparator
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      speed_encoder_pkg::field_t max_run, min_run, max_hold, min_hold;
      speed_encoder_pkg::field_t next_max_run, next_min_run, next_max_hold, next_min_hold;
      logic primed, next_primed;
      int   op_lvl, rp_lvl;

      // Holds follow new extremes so the first crossing is not starved
      always_comb begin
        next_max_run       = max_run;
        next_min_run       = min_run;
        next_max_hold      = max_hold;
        next_min_hold      = min_hold;
        next_primed        = primed;
        next_chan_state[gi] = chan_state[gi];
        chan_pkpk[gi]      = int'(max_hold) - int'(min_hold);
        op_lvl = int'(min_hold) + chan_pkpk[gi] * speed_encoder_pkg::OP_PERCENT
                 / speed_encoder_pkg::FULL_PERCENT;
        rp_lvl = int'(min_hold) + chan_pkpk[gi] * speed_encoder_pkg::RP_PERCENT
                 / speed_encoder_pkg::FULL_PERCENT;
        if (sample_valid_i) begin
          if (!primed) begin
            next_max_run  = smp[gi];
            next_min_run  = smp[gi];
            next_max_hold = smp[gi];
            next_min_hold = smp[gi];
            next_primed   = 1'b1;
          end else begin
            if (smp[gi] > max_run) next_max_run = smp[gi];
            if (smp[gi] < min_run) next_min_run = smp[gi];
            if (next_max_run > max_hold) next_max_hold = next_max_run;
            if (next_min_run < min_hold) next_min_hold = next_min_run;
            if (chan_pkpk[gi] >= speed_encoder_pkg::MIN_PKPK_G) begin
              if (!chan_state[gi] && int'(smp[gi]) >= op_lvl) begin
                next_chan_state[gi] = 1'b1;
                next_min_hold = min_run;
                next_min_run  = smp[gi];
              end else if (chan_state[gi] && int'(smp[gi]) <= rp_lvl) begin
                next_chan_state[gi] = 1'b0;
                next_max_hold = max_run;
                next_max_run  = smp[gi];
              end
            end
          end
        end
        chan_edge[gi] = next_chan_state[gi] != chan_state[gi];
      end

      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          max_run        <= '0;
          min_run        <= '0;
          max_hold       <= '0;
          min_hold       <= '0;
          primed         <= 1'b0;
          chan_state[gi] <= 1'b0;
        end else begin
          max_run        <= next_max_run;
          min_run        <= next_min_run;
          max_hold       <= next_max_hold;
          min_hold       <= next_min_hold;
          primed         <= next_primed;
          chan_state[gi] <= next_chan_state[gi];
        end
      end
    end
  endgenerate

  // Channel selection, direction and calibration
  logic       sel_valid, next_sel_valid;
  logic       sel_chan, next_sel_chan;
  logic [1:0] cal_count, next_cal_count;
  logic       next_calibrated;
  logic       sw_chan;
  logic       event_now;
  logic       a_leads;
  logic       forward;
  logic       is_warn;
  speed_encoder_pkg::pulse_kind_t event_kind;

  // Before selection either channel's first edge already yields a pulse
  always_comb begin
    next_sel_valid  = sel_valid;
    next_sel_chan   = sel_chan;
    next_cal_count  = cal_count;
    next_calibrated = calibrated_o;
    sw_chan = sel_valid ? sel_chan : !chan_edge[0];
    if (!sel_valid && (chan_edge[0] || chan_edge[1])) begin
      next_sel_valid = 1'b1;
      next_sel_chan  = sw_chan;
    end
    event_now = chan_edge[sw_chan];
    // Channel A leading B means the feature moves from pin one toward pin two
    a_leads = sw_chan ? (next_chan_state[1] == chan_state[0])
                      : (next_chan_state[0] != chan_state[1]);
    forward = a_leads ^ REVERSED_VARIANT;
    is_warn = WARNING_VARIANT && (chan_pkpk[sw_chan] <= speed_encoder_pkg::WARN_PKPK_G);
    event_kind = is_warn ? speed_encoder_pkg::KIND_WARN
               : (forward ? speed_encoder_pkg::KIND_FWD
                          : speed_encoder_pkg::KIND_REV);
    if (event_now && !calibrated_o) begin
      next_cal_count = cal_count + 2'h1;
      if (next_cal_count == speed_encoder_pkg::CAL_CROSSINGS) next_calibrated = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sel_valid     <= 1'b0;
      sel_chan      <= 1'b0;
      cal_count     <= 2'h0;
      calibrated_o  <= 1'b0;
      switch_chan_o <= 1'b0;
    end else begin
      sel_valid     <= next_sel_valid;
      sel_chan      <= next_sel_chan;
      cal_count     <= next_cal_count;
      calibrated_o  <= next_calibrated;
      switch_chan_o <= next_sel_chan;
    end
  end

  // Output pulse sequencer
  out_state_t                       state, next_state;
  logic [speed_encoder_pkg::CNT_W-1:0] count, next_count;
  logic [speed_encoder_pkg::CNT_W-1:0] high_cycles;
  speed_encoder_pkg::pulse_kind_t   kind, next_kind;
  logic                             pending, next_pending;
  logic                             err_level, next_err_level;

  // One crossing queued during the pre-pulse; more are merged since speed is only rate
  always_comb begin
    next_state     = state;
    next_count     = count + speed_encoder_pkg::CNT_ONE;
    next_kind      = kind;
    next_pending   = pending;
    next_err_level = err_level;
    case (kind)
      speed_encoder_pkg::KIND_FWD: high_cycles = speed_encoder_pkg::FWD_CYCLES;
      speed_encoder_pkg::KIND_REV: high_cycles = speed_encoder_pkg::REV_CYCLES;
      default:                     high_cycles = speed_encoder_pkg::WARN_CYCLES;
    endcase
    if (event_now) next_kind = event_kind;
    if (fault_i) begin
      if (state != ST_SAFE) begin
        next_state     = ST_SAFE;
        next_count     = speed_encoder_pkg::CNT_ZERO;
        next_err_level = 1'b0;
      end else if (count == speed_encoder_pkg::ERR_CYCLES - speed_encoder_pkg::CNT_ONE) begin
        next_count     = speed_encoder_pkg::CNT_ZERO;
        next_err_level = !err_level;
      end
      next_pending = 1'b0;
    end else begin
      case (state)
        ST_REST: begin
          next_count = speed_encoder_pkg::CNT_ZERO;
          if (event_now) next_state = ST_PRE;
        end
        ST_PRE: begin
          if (event_now) next_pending = 1'b1;
          if (count == speed_encoder_pkg::PRE_CYCLES - speed_encoder_pkg::CNT_ONE) begin
            next_state = ST_HIGH;
            next_count = speed_encoder_pkg::CNT_ZERO;
          end
        end
        ST_HIGH: begin
          if (event_now || pending) begin
            next_state   = ST_PRE;
            next_count   = speed_encoder_pkg::CNT_ZERO;
            next_pending = 1'b0;
          end else if (count >= high_cycles - speed_encoder_pkg::CNT_ONE) begin
            next_state = ST_REST;
            next_count = speed_encoder_pkg::CNT_ZERO;
          end
        end
        default: begin
          next_state     = ST_REST;
          next_count     = speed_encoder_pkg::CNT_ZERO;
          next_err_level = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state          <= ST_REST;
      count          <= speed_encoder_pkg::CNT_ZERO;
      kind           <= speed_encoder_pkg::KIND_FWD;
      pending        <= 1'b0;
      err_level      <= 1'b0;
      current_high_o <= 1'b0;
      safe_state_o   <= 1'b0;
    end else begin
      state          <= next_state;
      count          <= next_count;
      kind           <= next_kind;
      pending        <= next_pending;
      err_level      <= next_err_level;
      current_high_o <= (next_state == ST_HIGH) || (next_state == ST_SAFE && next_err_level);
      safe_state_o   <= next_state == ST_SAFE;
    end
  end

  // Sequencer, safe state and channel choice held to their rules
  a_pre_low: assert property (@(posedge clock_i) disable iff (rst_i)
    state == ST_PRE |-> !current_high_o) else $error("output high during pre-pulse");
  a_pre_full: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == ST_PRE && !fault_i && count != speed_encoder_pkg::PRE_CYCLES - 12'h001)
    |=> state == ST_PRE) else $error("pre-pulse cut short");
  a_high_follows: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == ST_PRE && !fault_i && count == speed_encoder_pkg::PRE_CYCLES - 12'h001)
    |=> (state == ST_HIGH && current_high_o)) else $error("no high after pre-pulse");
  a_high_truncate: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == ST_HIGH && event_now && !fault_i) |=> (state == ST_PRE && !current_high_o))
    else $error("crossing did not truncate high phase");
  a_event_pulse: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == ST_REST && event_now && !fault_i) |=> state == ST_PRE)
    else $error("crossing without pulse");
  a_fault_safe: assert property (@(posedge clock_i) disable iff (rst_i)
    fault_i |=> (state == ST_SAFE && safe_state_o)) else $error("fault not in safe state");
  a_safe_stays: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == ST_SAFE && fault_i) ##1 fault_i |=> state == ST_SAFE)
    else $error("left safe state during fault");
  a_sel_kept: assert property (@(posedge clock_i) disable iff (rst_i)
    sel_valid |=> (sel_valid && $stable(sel_chan))) else $error("switching channel changed");
  a_dir_next: assert property (@(posedge clock_i) disable iff (rst_i)
    (event_now && !is_warn) |=> kind == ($past(forward) ? speed_encoder_pkg::KIND_FWD
                                                         : speed_encoder_pkg::KIND_REV))
    else $error("direction not applied to next pulse");
  a_rest_low: assert property (@(posedge clock_i) disable iff (rst_i)
    state == ST_REST |-> !current_high_o) else $error("output high at rest");

endmodule

// File: bench/pulse_decoder_model.sv
`timescale 1ns/1ps
// Control unit side of the two-wire loop: counts pulses and times each high phase
module pulse_decoder_model (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        current_high_i,
  output logic [7:0]       pulse_count_o,
  output logic [11:0]      last_width_o
);
  logic [11:0] run;

  // Rate comes from the count alone, the kind from the width
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      run           <= 12'h000;
      pulse_count_o <= 8'h00;
      last_width_o  <= 12'h000;
    end else if (current_high_i) begin
      run <= run + 12'h001;
    end else if (run != 12'h000) begin
      pulse_count_o <= pulse_count_o + 8'h01; // Counted at the falling edge of the high phase
      last_width_o  <= run;
      run           <= 12'h000;
    end
  end
endmodule

// File: bench/speed_direction_pulse_encoder_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); end end
module speed_direction_pulse_encoder_bench;
  localparam speed_encoder_pkg::field_t P = 12'h064;
  localparam speed_encoder_pkg::field_t N = 12'hf9c;
  logic                          clock_i;
  logic                          rst_i;
  logic                          sample_valid_i;
  logic                          fault_i;
  speed_encoder_pkg::field_pair_t field;
  logic                          out;
  logic                          cal;
  logic                          sw;
  logic                          safe;
  logic                          out_rw;
  logic [7:0]                    cnt;
  logic [7:0]                    cnt_rw;
  logic [11:0]                   wid;
  logic [11:0]                   wid_rw;
  int                            n_mismatch;
  int                            n_checks;

  // Forward default device and a reversed, warning capable one fed the same field
  speed_direction_pulse_encoder dut (.clock_i(clock_i), .rst_i(rst_i),
    .sample_valid_i(sample_valid_i), .field_i(field), .fault_i(fault_i),
    .current_high_o(out), .calibrated_o(cal), .switch_chan_o(sw), .safe_state_o(safe));
  speed_direction_pulse_encoder #(.REVERSED_VARIANT(1'b1), .WARNING_VARIANT(1'b1)) dut_rw (
    .clock_i(clock_i), .rst_i(rst_i), .sample_valid_i(sample_valid_i), .field_i(field),
    .fault_i(fault_i), .current_high_o(out_rw), .calibrated_o(), .switch_chan_o(),
    .safe_state_o());
  pulse_decoder_model ecu (.clock_i(clock_i), .rst_i(rst_i), .current_high_i(out),
    .pulse_count_o(cnt), .last_width_o(wid));
  pulse_decoder_model ecu_rw (.clock_i(clock_i), .rst_i(rst_i), .current_high_i(out_rw),
    .pulse_count_o(cnt_rw), .last_width_o(wid_rw));

  // Clock at 10 MHz
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  task automatic final_report;
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // New field level on both channels, then settle for n clock edges and 1 ns past the last
  task automatic step(input speed_encoder_pkg::field_t a, input speed_encoder_pkg::field_t b,
                      input int n);
    @(posedge clock_i);
    field.chan_a <= a;
    field.chan_b <= b;
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // Reset with both channels parked low so the first sample primes the trackers
  task automatic do_reset(input speed_encoder_pkg::field_t lo);
    @(posedge clock_i);
    rst_i        <= 1'b1;
    field.chan_a <= lo;
    field.chan_b <= lo;
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask

  // A leads B: A is picked, B only steers direction
  task automatic t_forward;
    do_reset(N);
    step(P, N, 2000);
    `CHK(sw, 1'b0)
    `CHK(wid, speed_encoder_pkg::FWD_CYCLES)
    `CHK(wid_rw, speed_encoder_pkg::REV_CYCLES)
    step(P, P, 2000);
    `CHK(cnt, 8'h01)
    step(N, P, 2000);
    `CHK(wid, speed_encoder_pkg::FWD_CYCLES)
    `CHK(cal, 1'b0)
    step(N, N, 2000);
    step(P, N, 2000);
    `CHK(cnt, 8'h03)
    `CHK(cal, 1'b1)
    `CHK(sw, 1'b0)
  endtask

  // B leads A, then B turns back: the very next pulse flips kind
  task automatic t_reverse;
    do_reset(N);
    step(N, P, 2000);
    `CHK(sw, 1'b1)
    `CHK(wid, speed_encoder_pkg::REV_CYCLES)
    `CHK(wid_rw, speed_encoder_pkg::FWD_CYCLES)
    step(P, P, 2000);
    step(P, N, 2000);
    `CHK(wid, speed_encoder_pkg::REV_CYCLES)
    step(P, P, 2000);
    `CHK(wid, speed_encoder_pkg::FWD_CYCLES)
    `CHK(cnt, 8'h03)
  endtask

  // Amplitude of 22 G sits under the warning level
  task automatic t_warning;
    do_reset(12'hff5);
    step(12'h00b, 12'hff5, 2000);
    `CHK(wid_rw, speed_encoder_pkg::WARN_CYCLES)
    `CHK(wid, speed_encoder_pkg::FWD_CYCLES)
    `CHK(cal, 1'b0)
    // Samples not flagged valid are ignored, so a field swing gives no pulse
    @(posedge clock_i);
    sample_valid_i <= 1'b0;
    step(12'hff5, 12'hff5, 2000);
    `CHK(cnt, 8'h01)
    @(posedge clock_i);
    sample_valid_i <= 1'b1;
  endtask

  // Second crossing inside the low phase: the low phase wins, the high is cut
  task automatic t_truncate;
    do_reset(N);
    step(P, N, 100);
    step(N, N, 2200);
    `CHK(cnt, 8'h02)
    `CHK(wid, speed_encoder_pkg::REV_CYCLES)
    `CHK(out, 1'b0)
    // B moves alone, then A rises and falls again inside the high phase
    step(N, P, 100);
    step(P, P, 700);
    `CHK(out, 1'b1)
    step(N, P, 2000);
    `CHK(cnt, 8'h04)
    `CHK(wid, speed_encoder_pkg::FWD_CYCLES)
  endtask

  // Fault held across one error phase, then dropped
  task automatic t_fault;
    do_reset(N);
    fault_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    `CHK(safe, 1'b1)
    `CHK(out, 1'b0)
    repeat (2400) @(posedge clock_i);
    #1;
    `CHK(out, 1'b1)
    `CHK(safe, 1'b1)
    @(posedge clock_i);
    fault_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    `CHK(safe, 1'b0)
    `CHK(out, 1'b0)
  endtask

  // Main sequence
  initial begin
    rst_i          = 1'b1;
    fault_i        = 1'b0;
    sample_valid_i = 1'b1;
    field.chan_a   = N;
    field.chan_b   = N;
    n_mismatch     = 0;
    n_checks       = 0;
    t_forward;
    t_reverse;
    t_warning;
    t_truncate;
    t_fault;
    final_report;
  end

  // Watchdog well past the roughly 30000 cycles the scenarios need
  initial begin
    repeat (60000) @(posedge clock_i);
    n_mismatch++;
    final_report;
  end
endmodule
